/* File: common/dlc_pkg.sv */
// constants, types and helpers shared by the loop compensator files
package dlc_pkg;
  // data widths
  localparam int E_W = 6;
  localparam int X_W = 9;
  localparam int C_W = 12;
  localparam int P_W = 20;
  localparam int Y_W = 16;
  localparam int A_W = 23;
  localparam int KS_W = 3;
  localparam int SP_W = 10;
  localparam int PRD_W = 16;
  localparam int PH_W = 16;
  // rounding drops
  localparam int NUM_DROP = 3;
  localparam int DEN_DROP = 8;
  localparam int SCALE_DROP = 3;
  // modulator input scale: one lsb is 2**-15 of a cycle
  localparam int PWM_FRAC = 15;
  // error converter scale
  localparam int ADC_LSB_PER_V = 125;
  localparam int ADC_MV_PER_LSB = 8;
  // nonlinear gain stage knee and boost, and sample buffer depth
  localparam int NLG_KNEE = 4;
  localparam int NLG_BOOST_SH = 2;
  localparam int FIFO_DEPTH = 16;
  // cycles from taking a sample to the control effort
  localparam int LATENCY = 4;
  // amplifier gain codes
  localparam logic [1:0] GAIN_1X = 2'h0;
  localparam logic [1:0] GAIN_2X = 2'h1;
  localparam logic [1:0] GAIN_4X = 2'h2;
  localparam logic [1:0] GAIN_8X = 2'h3;
  // reset values
  localparam logic [1:0] RST_GAIN = GAIN_1X;
  localparam logic [SP_W-1:0] RST_SETPOINT = 10'h000;
  localparam logic [PRD_W-1:0] RST_PERIOD = 16'h0000;
  localparam logic [PH_W-1:0] RST_PHASE = 16'h0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_MUL = 5'h02,
    ST_SUM = 5'h04,
    ST_SCL = 5'h08,
    ST_OUT = 5'h10
  } dlc_state_t;

  // round to nearest and drop n low bits of a product
  function automatic logic signed [P_W-1:0] dlc_rnd(input logic signed [27:0] p, input int n);
    logic signed [27:0] r;
    r = (p + (28'sh0000001 <<< (n - 1))) >>> n;
    return P_W'(r);
  endfunction
endpackage

/* File: common/dlc_stream_if.sv */
// valid/ready stream between the sample buffer and the filter
`timescale 1ns/100ps
`default_nettype none
interface dlc_stream_if #(parameter int W = 6);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: dv/dlc_far_end.sv */
// far side model: error converter ahead of the block and modulator behind it
`timescale 1ns/100ps
`default_nettype none
module dlc_far_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] amp_gain_q,
  input wire logic signed [15:0] err_mv,
  input wire logic [1:0] mode,
  output logic [dlc_pkg::E_W-1:0] err_code,
  output logic u_ready
);
  int seed = 96741;
  int amp;
  int code;
  always_comb begin
    amp = int'(err_mv) * (1 << amp_gain_q);
    code = amp / dlc_pkg::ADC_MV_PER_LSB;
    // the converter clips instead of wrapping, as a real front end does
    if (code > 31) code = 31;
    if (code < -32) code = -32;
    err_code = code[5:0];
  end
  // mode 0 prompt, 1 random stalls, 2 stalled
  always @(posedge clk or posedge rst) begin
    if (rst) u_ready <= 1'b0;
    else if (mode == 2'h0) u_ready <= #2 1'b1;
    else if (mode == 2'h1) u_ready <= #2 (($random(seed) & 1) == 1);
    else u_ready <= #2 1'b0;
  end
endmodule
`default_nettype wire

/* File: dv/dlc_top_tb.sv */
// self-checking bench of the loop compensator with a result queue
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dlc_top_tb;
  typedef struct packed {logic [15:0] y; logic [15:0] cmp;} dlc_exp_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic err_valid = 1'b0;
  logic signed [15:0] err_mv = 16'sh0000;
  logic [1:0] amp_gain_sel = 2'h0;
  logic [1:0] mode = 2'h0;
  logic [9:0] setpoint_in = 10'h000;
  logic [15:0] period_in = 16'h0000;
  logic [15:0] phase_in = 16'h0000;
  logic [11:0] coef_b0 = 12'h000, coef_b1 = 12'h000, coef_b2 = 12'h000, coef_a1 = 12'h000, coef_a2 = 12'h000;
  logic [2:0] kscale = 3'h0;
  wire logic [5:0] err_data;
  wire logic err_ready_q, u_ready, u_valid_q;
  wire logic [1:0] amp_gain_q;
  wire logic [9:0] setpoint_q;
  wire logic [15:0] period_q, phase_q, u_data_q, pwm_cmp_q;
  int seed = 96741;
  int n_mismatch = 0;
  int total_checks = 0;
  int n, k, g, mv;
  dlc_exp_t exp_q[$];
  dlc_exp_t cur;
  longint hx1 = 0, hx2 = 0, hy1 = 0, hy2 = 0;
  always #12.5 clk = ~clk;
  dlc_top i_dlc_top (.clk(clk), .rst(rst), .err_valid(err_valid), .err_data(err_data), .err_ready_q(err_ready_q),
    .amp_gain_sel(amp_gain_sel), .amp_gain_q(amp_gain_q), .setpoint_in(setpoint_in), .setpoint_q(setpoint_q),
    .period_in(period_in), .period_q(period_q), .phase_in(phase_in), .phase_q(phase_q), .coef_b0(coef_b0),
    .coef_b1(coef_b1), .coef_b2(coef_b2), .coef_a1(coef_a1), .coef_a2(coef_a2), .kscale(kscale),
    .u_ready(u_ready), .u_valid_q(u_valid_q), .u_data_q(u_data_q), .pwm_cmp_q(pwm_cmp_q));
  dlc_far_end i_dlc_far_end (.clk(clk), .rst(rst), .amp_gain_q(amp_gain_q), .err_mv(err_mv), .mode(mode),
    .err_code(err_data), .u_ready(u_ready));
  function automatic longint sc(input logic [11:0] c);
    return longint'($signed(c));
  endfunction
  function automatic longint rnd(input longint p, input int n);
    return (p + (longint'(1) <<< (n - 1))) >>> n;
  endfunction
  task automatic predict(input logic [5:0] e);
    longint ev, x, acc, y;
    dlc_exp_t r;
    ev = longint'($signed(e));
    x = (ev < 4 && ev > -4) ? ev : (ev < 0 ? 12 - 4 * (-ev) : 4 * ev - 12);
    acc = rnd(sc(coef_b0) * x, 3) + rnd(sc(coef_b1) * hx1, 3) + rnd(sc(coef_b2) * hx2, 3)
      - rnd(sc(coef_a1) * hy1, 8) + rnd(sc(coef_a2) * hy2, 8);
    y = rnd(acc <<< kscale, 3);
    if (y > 32767) y = 32767;
    if (y < -32768) y = -32768;
    hx2 = hx1;
    hx1 = x;
    hy2 = hy1;
    hy1 = y;
    r.y = y[15:0];
    r.cmp = (y <= 0) ? 16'h0000 : 16'((y * longint'(period_in)) >>> 15);
    exp_q.push_back(r);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    $display("wait limit ran out at %0t", $time);
    conclude();
  endtask
  task automatic step();
    @(posedge clk);
    #2;
  endtask
  // offers one word and holds it until an edge that takes it
  task automatic push(input int v);
    int w;
    err_mv = 16'(v);
    err_valid = 1'b1;
    #1;
    predict(err_data);
    w = 0;
    @(negedge clk);
    while (err_ready_q !== 1'b1 && w < 400) begin
      @(negedge clk);
      w++;
    end
    if (w == 400) timeout();
    step();
  endtask
  task automatic drain();
    int w;
    w = 0;
    while (exp_q.size() != 0 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    if (w == 3000) timeout();
    repeat (8) step();
  endtask
  task automatic new_coefs();
    coef_b0 = 12'($random(seed));
    coef_b1 = 12'($random(seed));
    coef_b2 = 12'($random(seed));
    coef_a1 = 12'($random(seed));
    coef_a2 = 12'($random(seed));
  endtask
  // a result is taken at the edge after a low phase with valid and ready high
  always @(negedge clk) begin
    if (rst === 1'b0 && u_valid_q === 1'b1 && u_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(u_valid_q, 1'b0)
      end else begin
        cur = exp_q.pop_front();
        `CHK(u_data_q, cur.y)
        `CHK(pwm_cmp_q, cur.cmp)
      end
    end
  end
  initial begin
    @(negedge clk);
    `CHK({err_ready_q, u_valid_q, u_data_q, pwm_cmp_q}, 34'h0)
    `CHK({amp_gain_q, setpoint_q, period_q, phase_q}, {dlc_pkg::RST_GAIN, 42'h0})
    repeat (2) step();
    rst = 1'b0;
    step();
    `CHK(err_ready_q, 1'b1)
    $display("test reset done");
    for (g = 0; g < 4; g++) begin
      amp_gain_sel = 2'(g);
      setpoint_in = 10'($random(seed));
      phase_in = 16'($random(seed));
      period_in = 16'($random(seed)) | 16'h8000;
      step();
      @(negedge clk);
      `CHK(amp_gain_q, 2'(g))
      `CHK({setpoint_q, period_q, phase_q}, {setpoint_in, period_in, phase_in})
      step();
    end
    $display("test settings done");
    // every scale and gain, random stalls at the modulator
    for (g = 0; g < 8; g++) begin
      kscale = 3'(g);
      amp_gain_sel = 2'(g);
      new_coefs();
      mode = 2'h1;
      step();
      for (k = 0; k < 6; k++) push($random(seed) % 300);
      err_valid = 1'b0;
      drain();
    end
    $display("test filter done");
    // fixed delay from an idle start, effort stands while stalled
    mode = 2'h2;
    push(40);
    err_valid = 1'b0;
    n = 0;
    @(negedge clk);
    while (u_valid_q !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    if (n == 50) timeout();
    `CHK(n, dlc_pkg::LATENCY)
    repeat (3) @(negedge clk);
    `CHK(u_valid_q, 1'b1)
    mode = 2'h0;
    drain();
    $display("test latency done");
    // fill the buffer against a stalled modulator until it refuses
    mode = 2'h2;
    n = 0;
    err_valid = 1'b1;
    while (n < 40) begin
      mv = $random(seed) % 200;
      err_mv = 16'(mv);
      #1;
      @(negedge clk);
      if (err_ready_q !== 1'b1) break;
      predict(err_data);
      n++;
      step();
    end
    if (n == 40) timeout();
    `CHK(n >= dlc_pkg::FIFO_DEPTH && n < 40, 1'b1)
    repeat (4) @(negedge clk);
    `CHK(err_ready_q, 1'b0)
    mode = 2'h1;
    push(mv);
    err_valid = 1'b0;
    drain();
    $display("test fill done");
    // reset in mid-run must clear the history
    mode = 2'h0;
    push(120);
    push(-90);
    err_valid = 1'b0;
    amp_gain_sel = 2'h0;
    coef_b0 = 12'h040;
    rst = 1'b1;
    exp_q.delete();
    hx1 = 0;
    hx2 = 0;
    hy1 = 0;
    hy2 = 0;
    repeat (2) step();
    rst = 1'b0;
    step();
    // one count at unity gain: the first sum is exactly 8 only with a cleared history
    kscale = 3'h1;
    push(8);
    err_valid = 1'b0;
    drain();
    // small sum with no shift reaches the rounding check
    kscale = 3'h0;
    push(-16);
    err_valid = 1'b0;
    drain();
    $display("test mid reset done");
    conclude();
  end
endmodule
`default_nettype wire

/* File: logic/dlc_fifo.sv */
// sample buffer of flip-flops with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dlc_fifo #(
  parameter int W = 6,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready_q,
  dlc_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("dlc_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic in_ready_d;
  logic push, pop;

  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];

  always_comb begin
    push = in_valid & in_ready_q;
    pop = out_s.valid & out_s.ready;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    // registered ready: a full buffer refuses the next word
    in_ready_d = (cnt_d != (PW+1)'(DEPTH));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      in_ready_q <= in_ready_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ready is still low in the first cycle after reset with an empty buffer, so that cycle is left out
  a_fifo_full_refuse: assert property (!in_ready_q && !$past(rst) |-> cnt_q == (PW+1)'(DEPTH))
    else $error("fifo refuses while not full");
endmodule
`default_nettype wire

/* File: logic/dlc_gain_stage.sv */
// nonlinear gain stage: 6-bit error widened to the 9-bit filter input
`timescale 1ns/100ps
`default_nettype none
module dlc_gain_stage (
  input wire logic [dlc_pkg::E_W-1:0] err,
  output logic signed [dlc_pkg::X_W-1:0] gain_out
);
  logic signed [dlc_pkg::E_W:0] e7;
  logic [dlc_pkg::E_W:0] mag;
  logic [dlc_pkg::X_W-1:0] big;

  // small errors pass at unity to keep quantisation jitter low, large ones are boosted
  always_comb begin
    e7 = $signed({err[dlc_pkg::E_W-1], err});
    mag = err[dlc_pkg::E_W-1] ? 7'(-e7) : 7'(e7);
    big = (dlc_pkg::X_W'(mag) << dlc_pkg::NLG_BOOST_SH) - dlc_pkg::X_W'(3 * dlc_pkg::NLG_KNEE);
    if (mag < 7'(dlc_pkg::NLG_KNEE)) begin
      gain_out = dlc_pkg::X_W'(e7);
    end else if (err[dlc_pkg::E_W-1]) begin
      gain_out = $signed(-big);
    end else begin
      gain_out = $signed(big);
    end
  end
endmodule
`default_nettype wire

/* File: logic/dlc_top.sv */
// digital loop compensator: second-order filter from error samples to control effort
//
// How it works
// - output is b0*x0 + b1*x1 + b2*x2 - a1*y1 + a2*y2 per sample.
// - the summed terms are shifted left by the programmed scale amount.
// - amplifier gain ahead of the converter selects 1x, 2x, 4x or 8x.
// - each error count stands for 8 mV, 125 counts per volt.
// - one effort lsb moves duty by 2**-15 of a switching cycle.
// - effort appears a fixed number of cycles after the filter takes each sample.
// - setpoint, switching period, phase and coefficients are programmable.
// - 12-bit coefficients, 20-bit products, 16-bit signed effort.
// - numerator products drop 3 bits, scaling drops 3, denominator drops 8, rounded.
// - 6-bit error expanded by the nonlinear gain stage to 9 bits.
`timescale 1ns/100ps
`default_nettype none
module dlc_top #(
  parameter int FIFO_DEPTH = dlc_pkg::FIFO_DEPTH,
  parameter int KS_W = dlc_pkg::KS_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic err_valid,
  input wire logic [dlc_pkg::E_W-1:0] err_data,
  output logic err_ready_q,
  input wire logic [1:0] amp_gain_sel,
  output logic [1:0] amp_gain_q,
  input wire logic [dlc_pkg::SP_W-1:0] setpoint_in,
  output logic [dlc_pkg::SP_W-1:0] setpoint_q,
  input wire logic [dlc_pkg::PRD_W-1:0] period_in,
  output logic [dlc_pkg::PRD_W-1:0] period_q,
  input wire logic [dlc_pkg::PH_W-1:0] phase_in,
  output logic [dlc_pkg::PH_W-1:0] phase_q,
  input wire logic [dlc_pkg::C_W-1:0] coef_b0,
  input wire logic [dlc_pkg::C_W-1:0] coef_b1,
  input wire logic [dlc_pkg::C_W-1:0] coef_b2,
  input wire logic [dlc_pkg::C_W-1:0] coef_a1,
  input wire logic [dlc_pkg::C_W-1:0] coef_a2,
  input wire logic [KS_W-1:0] kscale,
  input wire logic u_ready,
  output logic u_valid_q,
  output logic [dlc_pkg::Y_W-1:0] u_data_q,
  output logic [dlc_pkg::PRD_W-1:0] pwm_cmp_q
);
  if (KS_W < 1 || KS_W > 3) begin : g_bad_ks
    $error("dlc_top scale shift width must be 1 to 3 bits");
  end
  if (dlc_pkg::ADC_LSB_PER_V * dlc_pkg::ADC_MV_PER_LSB != 1000) begin : g_bad_adc
    $error("dlc_top converter scale is inconsistent");
  end

  dlc_stream_if #(.W(dlc_pkg::E_W)) fifo_s ();

  // error counts arrive at 8 mV per lsb; the buffer absorbs a stalled modulator
  dlc_fifo #(
    .W(dlc_pkg::E_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(err_valid),
    .in_data(err_data),
    .in_ready_q(err_ready_q),
    .out_s(fifo_s.src)
  );

  logic signed [dlc_pkg::X_W-1:0] x_new;

  dlc_gain_stage u_gain (
    .err(fifo_s.data),
    .gain_out(x_new)
  );

  dlc_pkg::dlc_state_t state_q, state_d;

  logic signed [dlc_pkg::X_W-1:0] x0_q, x0_d, x1_q, x1_d, x2_q, x2_d;
  logic signed [dlc_pkg::Y_W-1:0] y1_q, y1_d, y2_q, y2_d;
  logic signed [dlc_pkg::C_W-1:0] b0_q, b0_d, b1_q, b1_d, b2_q, b2_d;
  logic signed [dlc_pkg::C_W-1:0] a1_q, a1_d, a2_q, a2_d;
  logic [KS_W-1:0] ks_q, ks_d;
  logic signed [dlc_pkg::P_W-1:0] pb0_q, pb0_d, pb1_q, pb1_d, pb2_q, pb2_d;
  logic signed [dlc_pkg::P_W-1:0] pa1_q, pa1_d, pa2_q, pa2_d;
  logic signed [dlc_pkg::A_W-1:0] acc_q, acc_d;
  logic signed [31:0] scl, srd;
  logic signed [dlc_pkg::Y_W-1:0] y_new;
  logic [31:0] pw;
  logic u_valid_d;
  logic [dlc_pkg::Y_W-1:0] u_data_d;
  logic [dlc_pkg::PRD_W-1:0] pwm_cmp_d;
  logic take;

  // only an idle filter drains the buffer, so a held effort backs up to err_ready_q
  assign fifo_s.ready = (state_q == dlc_pkg::ST_IDLE);
  assign take = fifo_s.valid & fifo_s.ready;

  always_comb begin
    state_d = state_q;
    x0_d = x0_q;
    x1_d = x1_q;
    x2_d = x2_q;
    y1_d = y1_q;
    y2_d = y2_q;
    b0_d = b0_q;
    b1_d = b1_q;
    b2_d = b2_q;
    a1_d = a1_q;
    a2_d = a2_q;
    ks_d = ks_q;
    pb0_d = pb0_q;
    pb1_d = pb1_q;
    pb2_d = pb2_q;
    pa1_d = pa1_q;
    pa2_d = pa2_q;
    acc_d = acc_q;
    u_valid_d = u_valid_q;
    u_data_d = u_data_q;
    pwm_cmp_d = pwm_cmp_q;
    // scale stage: shift left, then round away 3 bits and saturate to 16
    scl = 32'(acc_q) <<< ks_q;
    srd = (scl + (32'sh00000001 <<< (dlc_pkg::SCALE_DROP - 1))) >>> dlc_pkg::SCALE_DROP;
    if (srd > 32'sh00007fff) begin
      y_new = 16'sh7fff;
    end else if (srd < 32'shffff8000) begin
      y_new = 16'sh8000;
    end else begin
      y_new = 16'(srd);
    end
    // a negative effort asks for no pulse at all
    pw = 32'(y_new[dlc_pkg::Y_W-2:0]) * 32'(period_q);
    case (state_q)
      dlc_pkg::ST_IDLE: begin
        if (take) begin
          x0_d = x_new;
          // coefficients are latched per sample so a rewrite never tears one result
          b0_d = coef_b0;
          b1_d = coef_b1;
          b2_d = coef_b2;
          a1_d = coef_a1;
          a2_d = coef_a2;
          ks_d = kscale;
          state_d = dlc_pkg::ST_MUL;
        end
      end
      dlc_pkg::ST_MUL: begin
        pb0_d = dlc_pkg::dlc_rnd(28'(x0_q) * 28'(b0_q), dlc_pkg::NUM_DROP);
        pb1_d = dlc_pkg::dlc_rnd(28'(x1_q) * 28'(b1_q), dlc_pkg::NUM_DROP);
        pb2_d = dlc_pkg::dlc_rnd(28'(x2_q) * 28'(b2_q), dlc_pkg::NUM_DROP);
        pa1_d = dlc_pkg::dlc_rnd(28'(y1_q) * 28'(a1_q), dlc_pkg::DEN_DROP);
        pa2_d = dlc_pkg::dlc_rnd(28'(y2_q) * 28'(a2_q), dlc_pkg::DEN_DROP);
        state_d = dlc_pkg::ST_SUM;
      end
      dlc_pkg::ST_SUM: begin
        acc_d = 23'(pb0_q) + 23'(pb1_q) + 23'(pb2_q) - 23'(pa1_q) + 23'(pa2_q);
        state_d = dlc_pkg::ST_SCL;
      end
      dlc_pkg::ST_SCL: begin
        u_data_d = y_new;
        u_valid_d = 1'b1;
        pwm_cmp_d = (y_new > 16'sh0000) ? pw[dlc_pkg::PWM_FRAC +: dlc_pkg::PRD_W] : '0;
        x2_d = x1_q;
        x1_d = x0_q;
        y2_d = y1_q;
        y1_d = y_new;
        state_d = dlc_pkg::ST_OUT;
      end
      dlc_pkg::ST_OUT: begin
        if (u_ready) begin
          u_valid_d = 1'b0;
          state_d = dlc_pkg::ST_IDLE;
        end
      end
      default: begin
        u_valid_d = 1'b0;
        state_d = dlc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= dlc_pkg::ST_IDLE;
      x0_q <= '0;
      x1_q <= '0;
      x2_q <= '0;
      y1_q <= '0;
      y2_q <= '0;
      b0_q <= '0;
      b1_q <= '0;
      b2_q <= '0;
      a1_q <= '0;
      a2_q <= '0;
      ks_q <= '0;
      pb0_q <= '0;
      pb1_q <= '0;
      pb2_q <= '0;
      pa1_q <= '0;
      pa2_q <= '0;
      acc_q <= '0;
      u_valid_q <= 1'b0;
      u_data_q <= '0;
      pwm_cmp_q <= '0;
    end else begin
      state_q <= state_d;
      x0_q <= x0_d;
      x1_q <= x1_d;
      x2_q <= x2_d;
      y1_q <= y1_d;
      y2_q <= y2_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      a1_q <= a1_d;
      a2_q <= a2_d;
      ks_q <= ks_d;
      pb0_q <= pb0_d;
      pb1_q <= pb1_d;
      pb2_q <= pb2_d;
      pa1_q <= pa1_d;
      pa2_q <= pa2_d;
      acc_q <= acc_d;
      u_valid_q <= u_valid_d;
      u_data_q <= u_data_d;
      pwm_cmp_q <= pwm_cmp_d;
    end
  end

  // programmable settings toward the front end and modulator
  logic [1:0] amp_gain_d;
  logic [dlc_pkg::SP_W-1:0] setpoint_d;
  logic [dlc_pkg::PRD_W-1:0] period_d;
  logic [dlc_pkg::PH_W-1:0] phase_d;

  always_comb begin
    amp_gain_d = amp_gain_sel;
    setpoint_d = setpoint_in;
    period_d = period_in;
    phase_d = phase_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amp_gain_q <= dlc_pkg::RST_GAIN;
      setpoint_q <= dlc_pkg::RST_SETPOINT;
      period_q <= dlc_pkg::RST_PERIOD;
      phase_q <= dlc_pkg::RST_PHASE;
    end else begin
      amp_gain_q <= amp_gain_d;
      setpoint_q <= setpoint_d;
      period_q <= period_d;
      phase_q <= phase_d;
    end
  end

  // reference sum for checking, built from the current operands and compared with the sum two cycles later
  logic signed [dlc_pkg::A_W-1:0] mac_ref;
  always_comb begin
    mac_ref = 23'(dlc_pkg::dlc_rnd(28'(x0_q) * 28'(b0_q), dlc_pkg::NUM_DROP))
      + 23'(dlc_pkg::dlc_rnd(28'(x1_q) * 28'(b1_q), dlc_pkg::NUM_DROP))
      + 23'(dlc_pkg::dlc_rnd(28'(x2_q) * 28'(b2_q), dlc_pkg::NUM_DROP))
      - 23'(dlc_pkg::dlc_rnd(28'(y1_q) * 28'(a1_q), dlc_pkg::DEN_DROP))
      + 23'(dlc_pkg::dlc_rnd(28'(y2_q) * 28'(a2_q), dlc_pkg::DEN_DROP));
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take;
    state_q == dlc_pkg::ST_IDLE && fifo_s.valid;
  endsequence

  sequence s_compute;
    !u_valid_q [*4] ##1 u_valid_q;
  endsequence

  a_fixed_latency: assert property (s_take |-> s_compute)
    else $error("control effort not at fixed latency");

  a_mac_form: assert property (state_q == dlc_pkg::ST_MUL |-> ##2 acc_q == $past(mac_ref, 2))
    else $error("filter sum does not match difference equation");

  a_hist_advance: assert property (state_q == dlc_pkg::ST_SCL |=>
      x1_q == $past(x0_q) && x2_q == $past(x1_q) && y1_q == $signed(u_data_q))
    else $error("history did not shift with the sample");

  a_hist_hold: assert property (state_q != dlc_pkg::ST_SCL |=> $stable(x1_q) && $stable(y1_q))
    else $error("history moved without a sample");

  a_scale_round: assert property (state_q == dlc_pkg::ST_SCL && ks_q == '0
      && acc_q < 23'sh000800 && acc_q > -23'sh000800 |=>
      32'($signed(u_data_q)) * 8 - 32'($past(acc_q)) <= 4
      && 32'($past(acc_q)) - 32'($signed(u_data_q)) * 8 <= 3)
    else $error("scale stage rounding wrong");

  a_scale_shift: assert property (state_q == dlc_pkg::ST_SCL && ks_q == 3'(1)
      && acc_q == 23'sh000008 |=> u_data_q == 16'h0002)
    else $error("scale shift not applied");

  a_pwm_zero: assert property ($rose(u_valid_q) && $signed(u_data_q) <= 0 |-> pwm_cmp_q == '0)
    else $error("non-positive effort gave a pulse");

  a_pwm_bound: assert property ($rose(u_valid_q) |-> pwm_cmp_q < period_q || period_q == '0)
    else $error("pulse compare exceeds period");

  a_out_hold: assert property (u_valid_q && !u_ready |=> u_valid_q && $stable(u_data_q))
    else $error("effort dropped before acceptance");

  a_gain_follow: assert property ($changed(amp_gain_sel) |=> amp_gain_q == $past(amp_gain_sel))
    else $error("amplifier gain not applied");
endmodule
`default_nettype wire
